// [rtl/rmb_buf.sv]
`timescale 1ns/1ps
`include "rmb_defs.svh"
module rmb_buf (
  input wire logic clk_i,
  input wire logic rst_i,
  rmb_buf_if.buf_side bp
);
  import rmb_pkg::*;

  logic valid;
  logic [63:0] data;

  // Beat that uses the last byte lane of the held doubleword
  wire [3:0] lane_end = {1'b0, bp.lane} + bp.bytes;
  wire last_lane = lane_end >= `RMB_BUF_BYTES;

  // Held doubleword: dropped on a new burst, refilled by a fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid <= 1'b0;
    end else if (bp.start) begin
      valid <= 1'b0;
    end else if (bp.fill) begin
      valid <= 1'b1;
    end else if (bp.take && last_lane) begin
      valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (bp.fill) begin
      data <= bp.fill_data;
    end
  end

  assign bp.valid = valid;
  assign bp.data = data;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_new_burst_flush: assert property (bp.start |=> !valid)
    else $error("buffer data survived a new burst");
  a_word_two_beats: assert property (
    bp.fill && !bp.start && bp.bytes == 4'h4 && bp.lane == 3'h0 ##1 bp.take
    |=> valid)
    else $error("first word beat emptied the buffer");
  a_lane_end_empty: assert property (
    bp.take && last_lane && !bp.start && !bp.fill |=> !valid)
    else $error("buffer kept data past its last lane");
endmodule

// [rtl/rmb_buf_if.sv]
`timescale 1ns/1ps
interface rmb_buf_if;
  logic start;
  logic fill;
  logic [63:0] fill_data;
  logic take;
  logic [2:0] lane;
  logic [3:0] bytes;
  logic valid;
  logic [63:0] data;

  modport ctl (output start, fill, fill_data, take, lane, bytes, input valid, data);
  modport buf_side (input start, fill, fill_data, take, lane, bytes, output valid, data);
endinterface

// [rtl/rmb_defs.svh]
`ifndef RMB_DEFS_SVH
`define RMB_DEFS_SVH

// Register word indices on the bus (byte address = index * 4)
`define RMB_CTRL_BASE_IDX 6'h00
`define RMB_STATUS_IDX 6'h10

// Port control register fields
`define RMB_CTRL_EN_BIT 0
`define RMB_CTRL_EN_RST 1'b1

// Status register field positions
`define RMB_ST_ACTIVE_POS 0
`define RMB_ST_BUFVALID_POS 8
`define RMB_ST_BUFFERED_POS 16

// Merge buffer geometry and arbitration bound
`define RMB_BUF_BYTES 4'h8
`define RMB_MAX_WAIT 8'd128

`endif

// [rtl/rmb_pkg.sv]
package rmb_pkg;

  // Transfer size of one bus beat
  typedef enum logic [1:0] {
    RMB_SZ8 = 2'b00,
    RMB_SZ16 = 2'b01,
    RMB_SZ32 = 2'b10,
    RMB_SZ64 = 2'b11
  } rmb_size_t;

  // Bytes carried by one beat of the given size
  function automatic logic [3:0] rmb_bytes(input rmb_size_t size);
    rmb_bytes = 4'h1 << size;
  endfunction

endpackage

// [rtl/rmb_top.sv]
`timescale 1ns/1ps
`include "rmb_defs.svh"
// Operation
// - While a narrow burst drains its buffer, memory may serve other ports.
// - During a buffered burst only ports hitting open pages get memory.
// - Buffered ports fetch 64 bits into their buffer; beats come from it.
// - Unbuffered narrow beats each read memory; the port holds memory all burst.
// - Clearing a port's buffer-enable bit stops buffering on that port.
// - A buffered port must never wait more than 128 other fetches.
// - An unbuffered port granted after the buffered one yields runs its burst back to back.
// - A 32-bit buffered burst takes two beats per fetch, then waits.
// - Buffer only enabled, cacheable, unlocked, non-exclusive narrow multi-beat bursts.
// - Buffered data serves only the burst that fetched it.
module rmb_top #(
  parameter int NPORTS = 3,
  parameter int PW = 2,
  parameter int AW = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NPORTS-1:0] req_i,
  input wire logic [AW-1:0] req_addr_i [NPORTS],
  input rmb_pkg::rmb_size_t req_size_i [NPORTS],
  input wire logic [4:0] req_beats_i [NPORTS],
  input wire logic [NPORTS-1:0] req_cacheable_i,
  input wire logic [NPORTS-1:0] req_lock_i,
  input wire logic [NPORTS-1:0] req_excl_i,
  input wire logic [NPORTS-1:0] page_open_i,
  output logic [NPORTS-1:0] beat_valid_o,
  output logic [63:0] beat_data_o [NPORTS],
  output logic [NPORTS-1:0] done_o,
  output logic mem_req_o,
  output logic [PW-1:0] mem_port_o,
  output logic [AW-1:0] mem_addr_o,
  output logic mem_wide_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_rdata_i
);
  import rmb_pkg::*;

  // Per-port burst state
  logic [NPORTS-1:0] active;
  logic [NPORTS-1:0] buffered;
  logic [NPORTS-1:0] started;
  logic [NPORTS-1:0] need;
  logic [NPORTS-1:0] elig;
  logic [NPORTS-1:0] buf_valid;
  logic [NPORTS-1:0] ctrl_en;
  logic [4:0] left [NPORTS];
  logic [AW-1:0] addr [NPORTS];
  rmb_size_t size [NPORTS];
  logic [7:0] wait_cnt [NPORTS];

  // Arbiter state
  logic hold_valid;
  logic [PW-1:0] hold_port;
  logic [PW-1:0] rr;
  logic [PW-1:0] next_pick;
  logic found;
  int idx;

  rmb_buf_if bif [NPORTS] ();

  // Memory ack belonging to the current grant
  wire mem_done = mem_req_o & mem_ack_i;
  wire buf_busy = |(active & buffered & started);

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : gen_port
      wire start = req_i[g] & !active[g];
      wire buf_ok = ctrl_en[g] & req_cacheable_i[g] & !req_lock_i[g] & !req_excl_i[g]
                    & (req_beats_i[g] > 5'd1) & (req_size_i[g] != RMB_SZ64);
      wire acked = mem_done & (mem_port_o == PW'(g));
      wire take = active[g] & buffered[g] & bif[g].valid & (left[g] != 5'd0);
      wire beat = buffered[g] ? take : (active[g] & acked);
      wire last = beat & (left[g] == 5'd1);

      // Fetch demand: buffered ports only when their buffer ran dry
      assign need[g] = active[g] & (left[g] != 5'd0) & (!buffered[g] | !bif[g].valid);
      // Only open-page ports may slip in while a buffered burst runs
      assign elig[g] = need[g]
                       & (!buf_busy | page_open_i[g] | (buffered[g] & started[g]));
      assign buf_valid[g] = bif[g].valid;

      // Buffer control
      assign bif[g].start = start;
      assign bif[g].fill = acked & buffered[g];
      assign bif[g].fill_data = mem_rdata_i;
      assign bif[g].take = take;
      assign bif[g].lane = addr[g][2:0];
      assign bif[g].bytes = rmb_bytes(size[g]);

      rmb_buf u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bp(bif[g])
      );

      // Burst bookkeeping
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          active[g] <= 1'b0;
          buffered[g] <= 1'b0;
          started[g] <= 1'b0;
          left[g] <= 5'd0;
        end else if (start) begin
          active[g] <= req_beats_i[g] != 5'd0;
          buffered[g] <= buf_ok;
          started[g] <= 1'b0;
          left[g] <= req_beats_i[g];
        end else begin
          if (acked) begin
            started[g] <= 1'b1;
          end
          if (beat) begin
            left[g] <= left[g] - 5'd1;
            active[g] <= !last;
          end
        end
      end

      // Beat address and size
      always_ff @(posedge clk_i) begin
        if (start) begin
          addr[g] <= req_addr_i[g];
          size[g] <= req_size_i[g];
        end else if (beat) begin
          addr[g] <= addr[g] + AW'(rmb_bytes(size[g]));
        end
      end

      // Returned beats, registered
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          beat_valid_o[g] <= 1'b0;
          done_o[g] <= 1'b0;
          beat_data_o[g] <= 64'h0;
        end else begin
          beat_valid_o[g] <= beat;
          done_o[g] <= last;
          beat_data_o[g] <= buffered[g] ? bif[g].data : mem_rdata_i;
        end
      end

      // Grants to other ports while this one waits for a fetch
      always_ff @(posedge clk_i) begin
        if (rst_i || start || acked || !need[g]) begin
          wait_cnt[g] <= 8'h0;
        end else if (mem_done && wait_cnt[g] != 8'hFF) begin
          wait_cnt[g] <= wait_cnt[g] + 8'h1;
        end
      end

      a_wait_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        buffered[g] |-> wait_cnt[g] <= `RMB_MAX_WAIT)
        else $error("buffered port starved past the bound");
      a_disabled_direct: assert property (@(posedge clk_i) disable iff (rst_i)
        start && !ctrl_en[g] |=> !buffered[g])
        else $error("disabled port still buffered");
      a_uncached_direct: assert property (@(posedge clk_i) disable iff (rst_i)
        start && !req_cacheable_i[g] |=> !buffered[g])
        else $error("non-cacheable burst was buffered");
      a_single_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        start && (req_beats_i[g] == 5'd1 || req_size_i[g] == RMB_SZ64)
        |=> !buffered[g])
        else $error("single or wide burst was buffered");
    end
  endgenerate

  // Round-robin pick among eligible ports
  always_comb begin
    next_pick = '0;
    found = 1'b0;
    idx = 0;
    for (int i = 0; i < NPORTS; i++) begin
      idx = (int'(rr) + i) % NPORTS;
      if (!found && elig[idx]) begin
        found = 1'b1;
        next_pick = PW'(idx);
      end
    end
  end

  // Memory request; a held port keeps memory until its burst ends
  assign mem_req_o = hold_valid ? need[hold_port] : found;
  assign mem_port_o = hold_valid ? hold_port : next_pick;
  assign mem_addr_o = buffered[mem_port_o] ? {addr[mem_port_o][AW-1:3], 3'h0}
                                           : addr[mem_port_o];
  assign mem_wide_o = buffered[mem_port_o] | (size[mem_port_o] == RMB_SZ64);

  // Hold owner and rotate priority after each completed ownership
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_valid <= 1'b0;
      hold_port <= '0;
      rr <= '0;
    end else if (mem_done) begin
      if (!buffered[mem_port_o] && left[mem_port_o] > 5'd1) begin
        hold_valid <= 1'b1;
        hold_port <= mem_port_o;
      end else begin
        hold_valid <= 1'b0;
        rr <= (int'(mem_port_o) == NPORTS - 1) ? '0 : mem_port_o + PW'(1);
      end
    end
  end

  // Register bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire [5:0] wb_idx = wb_adr_i[7:2];
  wire ctrl_hit = (wb_idx >= `RMB_CTRL_BASE_IDX) && (wb_idx < 6'(NPORTS));
  wire status_hit = wb_idx == `RMB_STATUS_IDX;
  wire [PW-1:0] ctrl_sel = wb_idx[PW-1:0];
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Status: active, buffer holding data, buffered mode
  always_comb begin
    status_word = 32'h0;
    status_word[`RMB_ST_ACTIVE_POS +: NPORTS] = active;
    status_word[`RMB_ST_BUFVALID_POS +: NPORTS] = buf_valid;
    status_word[`RMB_ST_BUFFERED_POS +: NPORTS] = buffered;
  end

  assign rd_word = ctrl_hit ? {31'h0, ctrl_en[ctrl_sel]} : status_hit ? status_word : 32'h0;

  // One-cycle ack for every access; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h0;
    end
  end

  // Port control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en <= {NPORTS{`RMB_CTRL_EN_RST}};
    end else if (wb_req && wb_we_i && ctrl_hit && wb_sel_i[0]) begin
      ctrl_en[ctrl_sel] <= wb_dat_i[`RMB_CTRL_EN_BIT];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_open_page_only: assert property (
    mem_req_o && buf_busy && !hold_valid
    && !(buffered[mem_port_o] && started[mem_port_o]) |-> page_open_i[mem_port_o])
    else $error("closed-page port served during buffered burst");
  a_rearb_free: assert property (
    buf_busy && !hold_valid && !need[rr] && |(elig) |-> mem_req_o)
    else $error("memory idle while an open-page port waited");
  a_buf_wide: assert property (mem_req_o && buffered[mem_port_o] |-> mem_wide_o)
    else $error("buffered fetch not 64 bits wide");
  a_hold_burst: assert property (
    mem_done && !buffered[mem_port_o] && left[mem_port_o] > 5'd1
    |=> hold_valid && hold_port == $past(mem_port_o))
    else $error("unbuffered burst lost memory mid-burst");
  a_owner_only: assert property (hold_valid && mem_req_o |-> mem_port_o == hold_port)
    else $error("memory granted away from held burst");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule

// [sim/rmb_mem_model.sv]
`timescale 1ns/1ps
// Memory side: answers at once, or after two wait cycles when slow_i is high
module rmb_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [63:0] mem_rdata_o
);
  logic [1:0] wait_cnt;
  logic [63:0] last;
  // Ack once the wait has run out; data only with the ack
  assign mem_ack_o = mem_req_i && (!slow_i || wait_cnt == 2'h2);
  assign mem_rdata_o = mem_ack_o ? {~mem_addr_i, mem_addr_i} : ~last;
  // Wait counter and last value, inverted while idle
  always_ff @(posedge clk_i) begin
    wait_cnt <= (rst_i || mem_ack_o || !mem_req_i) ? 2'h0 : wait_cnt + 2'h1;
    last <= rst_i ? 64'h0 : mem_rdata_o;
  end
endmodule

// [sim/test_rmb_top.sv]
`timescale 1ns/1ps
module test_rmb_top;
  import rmb_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, slow = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, mem_addr_o;
  logic wb_ack_o, mem_req_o, mem_wide_o, mem_ack_i;
  logic [2:0] req_i = 0, req_cacheable_i = 0, req_lock_i = 0, req_excl_i = 0;
  logic [2:0] page_open_i = 3'h7, beat_valid_o, done_o, seen;
  logic [31:0] req_addr_i [3];
  rmb_size_t req_size_i [3];
  logic [4:0] req_beats_i [3];
  logic [63:0] beat_data_o [3], first [3], mem_rdata_i;
  logic [1:0] mem_port_o;
  int n_errors = 0, num_checks = 0, fetches [3], wides [3], beats [3];
  int grants [$];

  always #12.5 clk_i = ~clk_i;

  rmb_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_i, .req_addr_i, .req_size_i, .req_beats_i,
    .req_cacheable_i, .req_lock_i, .req_excl_i, .page_open_i, .beat_valid_o,
    .beat_data_o, .done_o, .mem_req_o, .mem_port_o, .mem_addr_o, .mem_wide_o,
    .mem_ack_i, .mem_rdata_i);
  rmb_mem_model MEM (.clk_i, .rst_i, .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // Tally fetches, wide fetches, beats and finished bursts per port
  always @(posedge clk_i) begin
    if (mem_req_o && mem_ack_i) begin
      fetches[mem_port_o]++;
      if (mem_wide_o) wides[mem_port_o]++;
      grants.push_back(mem_port_o);
    end
    for (int p = 0; p < 3; p++) begin
      if (beat_valid_o[p] === 1'b1) begin
        if (beats[p] == 0) first[p] = beat_data_o[p];
        beats[p]++;
      end
      if (done_o[p] === 1'b1) seen[p] = 1'b1;
    end
  end

  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (exp !== got) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic timed_out;
    check("wait ended", 1, 0);
    give_verdict;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat, output logic [31:0] q,
                    input logic [3:0] sel = 4'hF);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
      if (i > 20) timed_out;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  // Start a burst on one port; request stands for one edge
  task automatic start(int p, rmb_size_t s, int n, logic c, logic l, logic x);
    fetches[p] = 0;
    wides[p] = 0;
    beats[p] = 0;
    seen[p] = 0;
    @(posedge clk_i);
    req_addr_i[p] <= 32'h40;
    req_size_i[p] <= s;
    req_beats_i[p] <= 5'(n);
    req_cacheable_i[p] <= c;
    req_lock_i[p] <= l;
    req_excl_i[p] <= x;
    req_i[p] <= 1'b1;
    @(posedge clk_i);
    req_i <= 3'h0;
  endtask

  task automatic wait_done(int p, output int cyc);
    cyc = 0;
    while (seen[p] !== 1'b1) begin
      @(posedge clk_i);
      cyc++;
      if (cyc > 400) timed_out;
    end
    @(posedge clk_i);
  endtask

  task automatic run(int p, rmb_size_t s, int n, logic c, logic l, logic x, int ef, int ew);
    int cyc;
    start(p, s, n, c, l, x);
    wait_done(p, cyc);
    check("fetches", ef, fetches[p]);
    if (ew >= 0) check("wide fetches", ew, wides[p]);
    check("beats", n, beats[p]);
    check("first beat data", {~32'h40, 32'h40}, first[p]);
  endtask

  task automatic scen_regs;
    for (int p = 0; p < 3; p++) begin
      wb(0, 8'(4 * p), 0, rd);
      check("ctrl reset", 32'h1, rd & 32'h1);
    end
    wb(0, 8'h40, 32'h0, rd);
    check("status idle", 32'h0, rd);
    wb(1, 8'h04, 32'h0, rd);
    wb(0, 8'h04, 32'h0, rd);
    check("ctrl cleared", 32'h0, rd & 32'h1);
    wb(1, 8'h04, 32'h1, rd);
    wb(1, 8'h08, 32'h0, rd, 4'hE);
    wb(0, 8'h08, 32'h0, rd);
    check("ctrl narrow write", 32'h1, rd & 32'h1);
    wb(0, 8'h80, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
  endtask

  task automatic scen_modes;
    run(0, RMB_SZ32, 4, 1, 0, 0, 2, 2);
    // Short burst leaves half the dword in the buffer for the next burst to ignore
    run(0, RMB_SZ16, 2, 1, 0, 0, 1, 1);
    wb(0, 8'h40, 32'h0, rd);
    check("status held data", 32'h100, rd & 32'hFFFF);
    run(0, RMB_SZ16, 2, 1, 0, 0, 1, 1);
    run(0, RMB_SZ32, 4, 1, 0, 0, 2, 2);
    run(0, RMB_SZ16, 4, 1, 0, 0, 1, 1);
    run(1, RMB_SZ8, 8, 1, 0, 0, 1, 1);
    run(0, RMB_SZ32, 4, 0, 0, 0, 4, 0);
    run(2, RMB_SZ32, 4, 1, 1, 0, 4, 0);
    run(0, RMB_SZ32, 4, 1, 0, 1, 4, 0);
    run(0, RMB_SZ32, 1, 1, 0, 0, 1, 0);
    run(0, RMB_SZ64, 4, 1, 0, 0, 4, 4);
  endtask

  task automatic scen_disable;
    wb(1, 8'h00, 32'h0, rd);
    run(0, RMB_SZ32, 4, 1, 0, 0, 4, 0);
    wb(1, 8'h00, 32'h1, rd);
    slow <= 1;
    run(0, RMB_SZ32, 4, 1, 0, 0, 2, 2);
    slow <= 0;
  endtask

  // Buffered port 0 shares memory with open-page port 1; port 2 is off-page
  task automatic scen_share;
    int c0, c, i, last0, first1, first2, run1;
    page_open_i <= 3'b011;
    start(0, RMB_SZ32, 16, 1, 0, 0);
    for (i = 0; fetches[0] == 0; i++) begin
      @(posedge clk_i);
      if (i > 50) timed_out;
    end
    grants.delete();
    start(1, RMB_SZ64, 16, 1, 0, 0);
    start(2, RMB_SZ64, 4, 1, 0, 0);
    wait_done(0, c0);
    check("buffered burst in bound", 1, c0 <= 128);
    wait_done(1, c);
    wait_done(2, c);
    {last0, first1, first2, run1} = {-32'sd1, -32'sd1, -32'sd1, 32'sd0};
    foreach (grants[k]) begin
      if (grants[k] == 0) last0 = k;
      if (grants[k] == 1 && first1 < 0) first1 = k;
      if (grants[k] == 2 && first2 < 0) first2 = k;
    end
    for (i = first1; i >= 0 && i < first1 + 16 && i < grants.size(); i++)
      run1 += (grants[i] == 1);
    check("open page port served early", 1, first1 >= 0 && first1 < last0);
    check("closed page port held off", 1, first2 > last0);
    check("open page burst back to back", 16, run1);
    page_open_i <= 3'h7;
  endtask

  initial begin
    for (int p = 0; p < 3; p++) begin
      req_addr_i[p] = 32'h0;
      req_size_i[p] = RMB_SZ32;
      req_beats_i[p] = 5'h1;
    end
    seen = 3'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    scen_regs;
    scen_modes;
    scen_disable;
    scen_share;
    give_verdict;
  end
endmodule
